// ### sscs_host_model.sv
// guidance computer model shifting command words into the selector
module sscs_host_model (
   input  wire logic clk_in,         // system clock
   output logic      ser_strobe_out, // computer strobe
   output logic      ser_data_out,   // computer data
   output logic      gse_strobe_out, // ground strobe
   output logic      gse_data_out    // ground data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {ser_strobe_out, ser_data_out, gse_strobe_out, gse_data_out} = 4'h0;
   end
   // strobe held 3 cycles high and at least 3 low
   task automatic send(input logic [sscs_pkg::WORD_W-1:0] w, input bit gse);
      for (int i = sscs_pkg::WORD_W - 1; i >= 0; i--) begin
         @(negedge clk_in);
         if (gse) gse_data_out = w[i]; else ser_data_out = w[i];
         repeat (3) @(negedge clk_in);
         if (gse) gse_strobe_out = 1'b1; else ser_strobe_out = 1'b1;
         repeat (3) @(negedge clk_in);
         if (gse) gse_strobe_out = 1'b0; else ser_strobe_out = 1'b0;
      end
      // released line shows the inverse, never a stale bit
      if (gse) gse_data_out = ~w[0]; else ser_data_out = ~w[0];
   endtask
endmodule // sscs_host_model

// ### sscs_pkg.sv
// constants and types shared by the stage sequence command selector
package sscs_pkg;
   localparam int unsigned WORD_W      = 15;
   localparam int unsigned CODE_W      = 8;
   localparam int unsigned SEL_W       = 5;
   localparam int unsigned NUM_OUT     = 112;
   localparam int unsigned CNT_W       = 4;
   // word field positions, bit 14 shifted first
   localparam int unsigned CODE_LSB    = 7;
   localparam int unsigned SEL_LSB     = 2;
   localparam int unsigned READ_BIT    = 1;
   localparam int unsigned RST_BIT     = 0;
   localparam logic [CNT_W-1:0] LAST_BIT = 4'hE;
   localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
   localparam logic [NUM_OUT-1:0] OUT_ZERO = '0;
   // stage unit address decode: stage n answers to select bit n
   localparam int unsigned NUM_STAGE   = 5;
   localparam int unsigned CMD_GAP_MS  = 100;
   localparam int unsigned CLK_HZ      = 40000000;

   typedef enum logic [2:0] {
      SH_IDLE  = 3'h1,
      SH_SHIFT = 3'h2,
      SH_APPLY = 3'h4
   } sscs_shift_t;
endpackage : sscs_pkg

// ### sscs_selector.sv
// stage sequence command selector: serial word register and stage units
// How it works
// RULE1 - each stage unit drives at most one of its 112 outputs
// RULE2 - commands arrive at most every 100 ms; each completes far sooner
// RULE3 - 15-bit word shifts in serially and is held complete
// RULE4 - word splits into 8-bit code, 5 selects, read bit, reset bit
// RULE5 - read bit makes addressed unit drive its stored code's output
// RULE6 - reset bit clears every stage unit's stored bits
// RULE7 - select field picks which stage units take the code
// RULE8 - per-unit zero status true when all stored bits are zero
// RULE9 - per-unit internal power status output
// RULE10 - ground equipment and computer words behave identically
// RULE11 - outputs only pulse with read; all quiet after reset
// RULE12 - word shifts in most significant bit first
// RULE13 - stored code returns complemented on eight verify lines
// RULE14 - complemented code form executes as well
// RULE15 - read also auto-resets the unit
// RULE16 - computer checks verify lines zero before commanding
module sscs_selector (
   input  wire logic                       CLK_SYS_IN,   // 40 MHz clock
   input  wire logic                       RESET_IN,     // sync reset
   input  wire logic                       SER_STROBE_IN, // output transfer
   input  wire logic                       SER_DATA_IN,  // serial bit
   input  wire logic                       GSE_STROBE_IN, // ground strobe
   input  wire logic                       GSE_DATA_IN,  // ground bit
   input  wire logic [sscs_pkg::NUM_STAGE-1:0] INT_POWER_IN, // power pins
   output logic [sscs_pkg::WORD_W-1:0]     CMD_WORD_OUT, // held word
   output logic                            BUSY_OUT,     // shifting
   output logic [sscs_pkg::NUM_STAGE*sscs_pkg::NUM_OUT-1:0] CHAN_OUT, // outs
   output logic [sscs_pkg::NUM_STAGE*sscs_pkg::CODE_W-1:0]  VERIFY_OUT, // ver
   output logic [sscs_pkg::NUM_STAGE-1:0]  ZERO_OUT,     // unit clear
   output logic [sscs_pkg::NUM_STAGE-1:0]  INT_POWER_OUT // on internal power
);
   // pin inputs pass two flops
   logic [3:0] s1_q, s2_q;
   logic [sscs_pkg::NUM_STAGE-1:0] p1_q, p2_q;
   always_ff @(posedge CLK_SYS_IN) begin
      s1_q <= {SER_STROBE_IN, SER_DATA_IN, GSE_STROBE_IN, GSE_DATA_IN};
      s2_q <= s1_q;
      p1_q <= INT_POWER_IN;
      p2_q <= p1_q;
   end
   logic stb, dat, stb_prev_q;
   // either source feeds the same register path
   assign stb = s2_q[3] | s2_q[1];                                  // RULE10
   assign dat = s2_q[3] ? s2_q[2] : s2_q[0];

   sscs_pkg::sscs_shift_t st_q, st_d;
   logic [sscs_pkg::WORD_W-1:0] sh_q, sh_d, word_q, word_d;
   logic [sscs_pkg::CNT_W-1:0]  cnt_q, cnt_d;
   logic apply_q, apply_d;

   always_comb begin
      st_d    = st_q;
      sh_d    = sh_q;
      word_d  = word_q;
      cnt_d   = cnt_q;
      apply_d = 1'b0;
      case (st_q)
         sscs_pkg::SH_IDLE: begin
            if (stb && !stb_prev_q) begin
               sh_d  = {sh_q[sscs_pkg::WORD_W-2:0], dat};          // RULE12
               cnt_d = '0;
               st_d  = sscs_pkg::SH_SHIFT;
            end
         end
         sscs_pkg::SH_SHIFT: begin
            if (stb && !stb_prev_q) begin
               sh_d  = {sh_q[sscs_pkg::WORD_W-2:0], dat};          // RULE3
               cnt_d = cnt_q + 4'h1;
               if (cnt_q + 4'h1 == sscs_pkg::LAST_BIT)
                  st_d = sscs_pkg::SH_APPLY;
            end
         end
         sscs_pkg::SH_APPLY: begin
            word_d  = sh_q;                                         // RULE3
            apply_d = 1'b1;
            st_d    = sscs_pkg::SH_IDLE;
         end
         default: st_d = sscs_pkg::SH_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         st_q       <= sscs_pkg::SH_IDLE;
         sh_q       <= '0;
         word_q     <= '0;
         cnt_q      <= '0;
         apply_q    <= 1'b0;
         stb_prev_q <= 1'b0;
         BUSY_OUT   <= 1'b0;
         INT_POWER_OUT <= '0;
      end else begin
         st_q       <= st_d;
         sh_q       <= sh_d;
         word_q     <= word_d;
         cnt_q      <= cnt_d;
         apply_q    <= apply_d;
         stb_prev_q <= stb;
         BUSY_OUT   <= (st_d != sscs_pkg::SH_IDLE);
         INT_POWER_OUT <= p2_q;                                     // RULE9
      end
   end
   assign CMD_WORD_OUT = word_q;

   // field split
   logic [sscs_pkg::CODE_W-1:0] code;
   logic [sscs_pkg::SEL_W-1:0]  sel;
   assign code = word_q[sscs_pkg::CODE_LSB +: sscs_pkg::CODE_W];    // RULE4
   assign sel  = word_q[sscs_pkg::SEL_LSB +: sscs_pkg::SEL_W];      // RULE4

   genvar g;
   generate
      for (g = 0; g < sscs_pkg::NUM_STAGE; g++) begin : g_stage
         sscs_stage_unit u_unit (
            .clk_in     (CLK_SYS_IN),
            .rst_in     (RESET_IN),
            .load_in    (apply_q && !word_q[sscs_pkg::READ_BIT]),
            .sel_in     (sel[g]),                                   // RULE7
            .read_in    (apply_q && word_q[sscs_pkg::READ_BIT]),    // RULE5
            .clr_in     (apply_q && word_q[sscs_pkg::RST_BIT]),     // RULE6
            .code_in    (code),
            .chan_out   (CHAN_OUT[g*sscs_pkg::NUM_OUT +: sscs_pkg::NUM_OUT]),
            .verify_out (VERIFY_OUT[g*sscs_pkg::CODE_W +: sscs_pkg::CODE_W]),
            .zero_out   (ZERO_OUT[g])                               // RULE8
         );
      end
   endgenerate

   property p_word;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
         apply_q |-> (CMD_WORD_OUT == $past(sh_q));
   endproperty
   a_word: assert property (p_word) else $error("word not held"); // RULE3
   property p_done;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
         (st_q == sscs_pkg::SH_APPLY)
         |=> !BUSY_OUT ##1 (st_q == sscs_pkg::SH_IDLE);
   endproperty
   a_done: assert property (p_done) else $error("apply slow"); // RULE2
   c_word: cover property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      apply_q && word_q[sscs_pkg::READ_BIT]);
   c_gse: cover property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      s2_q[1] && !s2_q[3]);
endmodule // sscs_selector

// ### sscs_stage_unit.sv
// one stage selector unit: code store, verify, decode, execute
module sscs_stage_unit (
   input  wire logic                          clk_in,       // system clock
   input  wire logic                          rst_in,       // sync reset
   input  wire logic                          load_in,      // store code pulse
   input  wire logic                          sel_in,       // unit addressed
   input  wire logic                          read_in,      // execute pulse
   input  wire logic                          clr_in,       // forced reset
   input  wire logic [sscs_pkg::CODE_W-1:0]   code_in,      // function code
   output logic      [sscs_pkg::NUM_OUT-1:0]  chan_out,     // output circuits
   output logic      [sscs_pkg::CODE_W-1:0]   verify_out,   // complement lines
   output logic                               zero_out      // register clear
);
   logic [sscs_pkg::CODE_W-1:0]  code_q, code_d;
   logic                         latched_q, latched_d;
   logic [sscs_pkg::NUM_OUT-1:0] chan_q, chan_d;
   logic [sscs_pkg::CODE_W-1:0]  idx;

   always_comb begin
      code_d    = code_q;
      latched_d = latched_q;
      chan_d    = sscs_pkg::OUT_ZERO;                             // RULE11
      // complement form executes too: pick true form if in range
      idx = (code_q < 8'(sscs_pkg::NUM_OUT)) ? code_q : ~code_q;  // RULE14
      if (clr_in) begin
         code_d    = sscs_pkg::CODE_ZERO;                         // RULE6
         latched_d = 1'b0;
      end else if (sel_in && read_in && latched_q) begin
         if (idx < 8'(sscs_pkg::NUM_OUT))
            chan_d[idx[6:0]] = 1'b1;                              // RULE1 RULE5
         code_d    = sscs_pkg::CODE_ZERO;                         // RULE15
         latched_d = 1'b0;
      end else if (sel_in && load_in) begin                       // RULE7
         code_d    = code_in;
         latched_d = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         code_q    <= sscs_pkg::CODE_ZERO;
         latched_q <= 1'b0;
         chan_q    <= sscs_pkg::OUT_ZERO;
         verify_out <= sscs_pkg::CODE_ZERO;
         zero_out  <= 1'b1;
      end else begin
         code_q    <= code_d;
         latched_q <= latched_d;
         chan_q    <= chan_d;
         // verify lines read zero when nothing is latched
         verify_out <= latched_d ? ~code_d : sscs_pkg::CODE_ZERO; // RULE13
         zero_out  <= (code_d == sscs_pkg::CODE_ZERO) && !latched_d; // RULE8
      end
   end
   assign chan_out = chan_q;

   property p_onehot;
      @(posedge clk_in) disable iff (rst_in) $onehot0(chan_q);
   endproperty
   a_onehot: assert property (p_onehot) else $error("two outputs on"); // RULE1
   property p_verify;
      @(posedge clk_in) disable iff (rst_in)
         (sel_in && load_in && !clr_in && !read_in && !latched_q)
         |=> (verify_out == ~$past(code_in));
   endproperty
   a_verify: assert property (p_verify) else $error("bad verify"); // RULE13
   property p_clear;
      @(posedge clk_in) disable iff (rst_in)
         clr_in |=> (zero_out && code_q == sscs_pkg::CODE_ZERO);
   endproperty
   a_clear: assert property (p_clear) else $error("reset not clear"); // RULE6
   property p_exec;
      @(posedge clk_in) disable iff (rst_in)
         (sel_in && read_in && latched_q && !clr_in && code_q == 8'h05)
         |=> chan_q[5] ##1 (chan_q == sscs_pkg::OUT_ZERO);
   endproperty
   a_exec: assert property (p_exec) else $error("exec fault"); // RULE5
   property p_auto;
      @(posedge clk_in) disable iff (rst_in)
         (sel_in && read_in && latched_q) |=> zero_out;
   endproperty
   a_auto: assert property (p_auto) else $error("no auto reset"); // RULE15
   property p_nosel;
      @(posedge clk_in) disable iff (rst_in)
         (!sel_in && !clr_in) |=> $stable(code_q);
   endproperty
   a_nosel: assert property (p_nosel) else $error("unaddressed load"); // RULE7
   property p_idle;
      @(posedge clk_in) disable iff (rst_in)
         !(read_in && sel_in) |=> (chan_q == sscs_pkg::OUT_ZERO);
   endproperty
   a_idle: assert property (p_idle) else $error("output w/o read"); // RULE11
   c_exec: cover property (@(posedge clk_in) disable iff (rst_in)
      chan_q != sscs_pkg::OUT_ZERO);
   c_comp: cover property (@(posedge clk_in) disable iff (rst_in)
      read_in && sel_in && latched_q && code_q >= 8'(sscs_pkg::NUM_OUT));
endmodule // sscs_stage_unit

// ### stage_sequence_command_selector_test.sv
// self-checking bench for the stage sequence command selector
module stage_sequence_command_selector_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NS = sscs_pkg::NUM_STAGE;
   localparam int NO = sscs_pkg::NUM_OUT;
   logic                        clk = 1'b0, rst = 1'b1;
   logic                        ss, sd, gs, gd, busy;
   logic [NS-1:0]               pwr_in = 5'h00, pwr_out, zero;
   logic [sscs_pkg::WORD_W-1:0] word, rw;
   logic [NS*NO-1:0]            chan, cap = '0, exp_cap;
   logic [NS*8-1:0]             ver;
   logic [15:0]                 lfsr = 16'h001A;
   int                          error_cnt = 0, n_tests = 0, hits = 0;
   int                          exp_hits, code_m[NS];
   bit                          held[NS];
   logic [15:0]                 dir[14] = '{16'h0287, 16'h37C4, 16'h37C6,
      16'hCF88, 16'hCF8A, 16'h3810, 16'h3812, 16'h00FC, 16'h00FF,
      16'h9520, 16'h9522, 16'h8184, 16'h0284, 16'h0286};
   always #12.5 clk = ~clk;
   sscs_host_model u_sscs_host_model (.clk_in(clk), .ser_strobe_out(ss),
      .ser_data_out(sd), .gse_strobe_out(gs), .gse_data_out(gd));
   sscs_selector u_sscs_selector (.CLK_SYS_IN(clk), .RESET_IN(rst),
      .SER_STROBE_IN(ss), .SER_DATA_IN(sd), .GSE_STROBE_IN(gs),
      .GSE_DATA_IN(gd), .INT_POWER_IN(pwr_in), .CMD_WORD_OUT(word),
      .BUSY_OUT(busy), .CHAN_OUT(chan), .VERIFY_OUT(ver),
      .ZERO_OUT(zero), .INT_POWER_OUT(pwr_out));
   // one-cycle pulses are collected so none slips past
   always @(posedge clk) begin
      cap = cap | chan;
      hits = hits + $countones(chan);
   end
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic [NS*NO-1:0] got, exp, input string m);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic report_and_stop;
      if (error_cnt == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apply(input logic [14:0] w, input bit gse);
      int idx;
      logic [7:0] ev;
      exp_cap = '0;
      exp_hits = 0;
      for (int g = 0; g < NS; g++) begin
         if (w[0]) held[g] = 0;
         else if (w[2+g] && w[1] && held[g]) begin
            idx = (code_m[g] < NO) ? code_m[g] : 255 - code_m[g];
            if (idx < NO) begin
               exp_cap[g*NO+idx] = 1'b1;
               exp_hits++;
            end
            held[g] = 0;
         end else if (w[2+g] && !w[1]) begin
            code_m[g] = w[14:7];
            held[g] = 1;
         end
      end
      cap = '0;
      hits = 0;
      pwr_in = lfsr[NS-1:0];
      fork
         u_sscs_host_model.send(w, gse);
         begin
            repeat (20) @(negedge clk);
            check(busy, 1'b1, "busy while shifting");
         end
      join
      repeat (10) @(negedge clk);
      check(word, w, "held word");
      check(busy, 1'b0, "busy after word");
      check(cap, exp_cap, "output circuits");
      check(hits, exp_hits, "pulse count");
      check(pwr_out, pwr_in, "internal power");
      for (int g = 0; g < NS; g++) begin
         ev = held[g] ? ~8'(code_m[g]) : 8'h00;
         check(ver[g*8+:8], ev, "verify");
         check(zero[g], !held[g], "zero status");
      end
   endtask
   // host side: stale stores are force-cleared before a new code
   task automatic cmd(input logic [14:0] w, input bit gse);
      if (!w[1] && !w[0] && (|ver)) apply(15'h0001, 1'b0);
      apply(w, gse);
   endtask
   task automatic reset_check;
      check(chan, '0, "outputs in reset");
      check(ver, '0, "verify in reset");
      check(zero, 5'h1F, "zero in reset");
      check(busy, 1'b0, "busy in reset");
      check(pwr_out, '0, "power status in reset");
   endtask
   initial begin
      repeat (8) @(negedge clk);
      reset_check();
      rst = 1'b0;
      @(negedge clk);
      // refused read, boundary codes, complement form, priority, gse path
      foreach (dir[k]) cmd(dir[k][14:0], dir[k][15]);
      repeat (150) begin
         lfsr = lfsr_next(lfsr);
         rw = lfsr[14:0];
         rw[0] = (lfsr[15:12] == 4'h0);
         if (rw[14:7] == 8'h00) rw[7] = 1'b1;
         cmd(rw, lfsr[15] & lfsr[5]);
      end
      apply(15'h0B04, 1'b0);
      rst = 1'b1;
      repeat (3) @(negedge clk);
      reset_check();
      check(word, '0, "word in reset");
      foreach (held[g]) held[g] = 0;
      rst = 1'b0;
      @(negedge clk);
      apply(15'h0B04, 1'b0);
      apply(15'h0B06, 1'b0);
      report_and_stop();
   end
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      report_and_stop();
   end
endmodule // stage_sequence_command_selector_test
